/* fcs_pkg.sv */
// package for the flash configuration/status register bank
// assumes a single aclk domain and an axi4-lite master on the far side
package fcs_pkg;

	// ---------------------------------------------------------------
	// register byte addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_PIN_DRIVE = 8'h00;
	localparam logic [7:0] ADDR_POWER_PROG = 8'h04;
	localparam logic [7:0] ADDR_QUAD_CFG = 8'h08;
	localparam logic [7:0] ADDR_COMMAND = 8'h0c;
	localparam logic [7:0] ADDR_PROG_ADDR = 8'h10;
	localparam logic [7:0] ADDR_BLOCK_LOCK = 8'h14;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int HOLD_RESET_SEL_BIT = 7;
	localparam int DRIVE_HI_BIT = 6;
	localparam int DRIVE_LO_BIT = 5;
	localparam int PROTECT_SCHEME_BIT = 2;
	localparam int SLEEP_DEPTH_BIT = 7;
	localparam int PROG_MODE_BIT = 6;
	localparam int FOUR_LINE_BIT = 1;
	localparam int CMD_OP_LO = 0;
	localparam int CMD_BLOCK_LO = 8;
	localparam int CMD_DATA_LO = 24;

	// ---------------------------------------------------------------
	// sizes and reset values
	// ---------------------------------------------------------------
	localparam int NUM_BLOCKS = 16;
	localparam int BLOCK_IDX_W = 4;
	localparam int PROG_ADDR_W = 24;
	localparam logic [7:0] PIN_DRIVE_RST = 8'h20;
	localparam logic [7:0] POWER_PROG_RST = 8'h00;
	localparam logic [7:0] QUAD_CFG_RST = 8'h00;
	localparam logic [NUM_BLOCKS-1:0] LOCKS_RST = 16'hffff;

	// ---------------------------------------------------------------
	// opcodes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_BLOCK_LOCK = 8'h36;
	localparam logic [7:0] OP_BLOCK_UNLOCK = 8'h39;
	localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
	localparam logic [7:0] OP_ULTRA_DOWN = 8'h79;
	localparam logic [7:0] OP_WAKE = 8'hab;
	localparam logic [7:0] OP_SEQ_PROGRAM = 8'h5a;
	localparam logic [7:0] OP_SEQ_END = 8'h5b;

	// ---------------------------------------------------------------
	// drive level encodings and bus responses
	// ---------------------------------------------------------------
	localparam logic [1:0] DRV_RESERVED = 2'h0;
	localparam logic [1:0] DRV_FULL = 2'h1;
	localparam logic [1:0] DRV_TWO_THIRDS = 2'h2;
	localparam logic [1:0] DRV_ONE_THIRD = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'h0,
		PWR_DEEP = 2'h1,
		PWR_ULTRA = 2'h3
	} fcs_power_e;

	typedef struct packed {
		logic full;
		logic two_thirds;
		logic one_third;
		logic reserved;
	} fcs_drive_s;

	typedef struct packed {
		logic strobe;
		logic [PROG_ADDR_W-1:0] addr;
		logic [7:0] data;
	} fcs_prog_s;

endpackage

/* fcs_regs.sv */
// flash configuration/status register bank with axi4-lite slave port
// assumes aclk at 20 mhz; the shared hold/reset pin arrives asynchronously
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.

// How it works
// - select bit 7 picks hold at 0 and reset at 1, default 0.
// - the role choice applies only while four-line enable is clear.
// - with four-line enable set the pin neither holds nor resets.
// - drive bits 6:5: 00 reserved, 01 full, 10 2/3, 11 1/3.
// - scheme select 0 protects by the first register's region bits.
// - scheme select 1 protects by per-block lock bits.
// - every lock bit is 1 after power-on and any device reset.
// - under block scheme 36h locks and 39h unlocks a block.
// - with sleep depth 0, b9h enters ultra sleep like 79h.
// - entering ultra sleep discards the sram buffer.
// - with sleep depth 1, b9h enters deep sleep and keeps the buffer.
// - only opcode abh or a pin reset ends either sleep state.
// - chip select activity alone never ends sleep.
// - a read-only flag shows byte/page versus sequential programming.
// - the program mode flag clears at power-up and every device reset.
// - in sequential mode only the first transfer uses the address.
module fcs_regs (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// shared hold/reset pin, active low at the pin
	input wire logic hold_reset_pin_n,
	output logic hold_active,
	output logic pin_reset_active,
	// array side controls
	output fcs_pkg::fcs_drive_s drive_level,
	output logic region_protect_en,
	output logic block_protect_en,
	output logic [fcs_pkg::NUM_BLOCKS-1:0] block_locked,
	output fcs_pkg::fcs_power_e power_state,
	output logic sram_retain,
	output logic sram_discard,
	output logic program_mode_flag,
	output fcs_pkg::fcs_prog_s prog_req
);

	// ---------------------------------------------------------------
	// decode helpers
	// ---------------------------------------------------------------
	function automatic fcs_pkg::fcs_drive_s drive_decode(input logic [1:0] f);
		fcs_pkg::fcs_drive_s d;
		d = '0;
		d.reserved = (f == fcs_pkg::DRV_RESERVED);
		d.full = (f == fcs_pkg::DRV_FULL);
		d.two_thirds = (f == fcs_pkg::DRV_TWO_THIRDS);
		d.one_third = (f == fcs_pkg::DRV_ONE_THIRD);
		return d;
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		return (a == fcs_pkg::ADDR_PIN_DRIVE) ||
			(a == fcs_pkg::ADDR_POWER_PROG) ||
			(a == fcs_pkg::ADDR_QUAD_CFG) ||
			(a == fcs_pkg::ADDR_COMMAND) ||
			(a == fcs_pkg::ADDR_PROG_ADDR) ||
			(a == fcs_pkg::ADDR_BLOCK_LOCK);
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic pin_meta_q;
	logic pin_sync_q;
	logic aw_have_q;
	logic w_have_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic hold_reset_sel_q;
	logic [1:0] drive_field_q;
	logic protect_scheme_select_q;
	logic sleep_depth_select_q;
	logic four_line_enable_q;
	logic program_mode_flag_q;
	logic [fcs_pkg::NUM_BLOCKS-1:0] locks_q;
	fcs_pkg::fcs_power_e power_q;
	logic sram_discard_q;
	logic [fcs_pkg::PROG_ADDR_W-1:0] base_addr_q;
	logic [fcs_pkg::PROG_ADDR_W-1:0] next_addr_q;
	fcs_pkg::fcs_prog_s prog_q;

	logic wr_fire;
	logic pin_low;
	logic dev_reset;
	logic cmd_fire;
	logic [7:0] cmd_op;
	logic [fcs_pkg::BLOCK_IDX_W-1:0] cmd_block;
	logic [7:0] cmd_data;

	// ---------------------------------------------------------------
	// shared pin synchroniser and role
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta_q <= 1'b1;
			pin_sync_q <= 1'b1;
		end else begin
			pin_meta_q <= hold_reset_pin_n;
			pin_sync_q <= pin_meta_q;
		end
	end

	assign pin_low = ~pin_sync_q;
	// in four-line mode the pin is data only, so neither role may fire
	assign hold_active = pin_low & ~four_line_enable_q & ~hold_reset_sel_q;
	assign pin_reset_active = pin_low & ~four_line_enable_q & hold_reset_sel_q;
	// a pin reset re-initialises volatile state but not the config registers
	assign dev_reset = pin_reset_active;

	// ---------------------------------------------------------------
	// axi4-lite write channel
	// ---------------------------------------------------------------
	assign s_axi_awready = ~aw_have_q & ~bvalid_q;
	assign s_axi_wready = ~w_have_q & ~bvalid_q;
	assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= fcs_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= is_mapped(aw_addr_q) ? fcs_pkg::RESP_OKAY :
				fcs_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	// only the documented fields are stored; reserved bits have no flop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_reset_sel_q <= fcs_pkg::PIN_DRIVE_RST[fcs_pkg::HOLD_RESET_SEL_BIT];
			drive_field_q <= fcs_pkg::PIN_DRIVE_RST[fcs_pkg::DRIVE_HI_BIT:fcs_pkg::DRIVE_LO_BIT];
			protect_scheme_select_q <= fcs_pkg::PIN_DRIVE_RST[fcs_pkg::PROTECT_SCHEME_BIT];
		end else if (wr_fire && w_strb_q[0] &&
				aw_addr_q == fcs_pkg::ADDR_PIN_DRIVE) begin
			hold_reset_sel_q <= w_data_q[fcs_pkg::HOLD_RESET_SEL_BIT];
			drive_field_q <= w_data_q[fcs_pkg::DRIVE_HI_BIT:fcs_pkg::DRIVE_LO_BIT];
			protect_scheme_select_q <= w_data_q[fcs_pkg::PROTECT_SCHEME_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sleep_depth_select_q <= fcs_pkg::POWER_PROG_RST[fcs_pkg::SLEEP_DEPTH_BIT];
		end else if (wr_fire && w_strb_q[0] &&
				aw_addr_q == fcs_pkg::ADDR_POWER_PROG) begin
			// the program mode bit is read-only and ignores this write
			sleep_depth_select_q <= w_data_q[fcs_pkg::SLEEP_DEPTH_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			four_line_enable_q <= fcs_pkg::QUAD_CFG_RST[fcs_pkg::FOUR_LINE_BIT];
		end else if (wr_fire && w_strb_q[0] &&
				aw_addr_q == fcs_pkg::ADDR_QUAD_CFG) begin
			four_line_enable_q <= w_data_q[fcs_pkg::FOUR_LINE_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			base_addr_q <= '0;
		end else if (wr_fire && w_strb_q[0] &&
				aw_addr_q == fcs_pkg::ADDR_PROG_ADDR) begin
			base_addr_q <= w_data_q[fcs_pkg::PROG_ADDR_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// command decode
	// ---------------------------------------------------------------
	assign cmd_fire = wr_fire && w_strb_q[0] &&
		aw_addr_q == fcs_pkg::ADDR_COMMAND;
	assign cmd_op = w_data_q[fcs_pkg::CMD_OP_LO +: 8];
	assign cmd_block = w_data_q[fcs_pkg::CMD_BLOCK_LO +: fcs_pkg::BLOCK_IDX_W];
	assign cmd_data = w_data_q[fcs_pkg::CMD_DATA_LO +: 8];

	// ---------------------------------------------------------------
	// power-down state
	// ---------------------------------------------------------------
	// exit needs the wake opcode or a pin reset; there is deliberately no chip select path
	always_ff @(posedge aclk) begin
		if (!aresetn || dev_reset) begin
			power_q <= fcs_pkg::PWR_ACTIVE;
		end else if (cmd_fire) begin
			case (power_q)
				fcs_pkg::PWR_ACTIVE: begin
					if (cmd_op == fcs_pkg::OP_ULTRA_DOWN)
						power_q <= fcs_pkg::PWR_ULTRA;
					else if (cmd_op == fcs_pkg::OP_POWER_DOWN)
						power_q <= sleep_depth_select_q ? fcs_pkg::PWR_DEEP :
							fcs_pkg::PWR_ULTRA;
				end
				fcs_pkg::PWR_DEEP, fcs_pkg::PWR_ULTRA: begin
					if (cmd_op == fcs_pkg::OP_WAKE)
						power_q <= fcs_pkg::PWR_ACTIVE;
				end
				default: power_q <= fcs_pkg::PWR_ACTIVE;
			endcase
		end
	end

	// one-cycle pulse telling the buffer to drop its contents
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sram_discard_q <= 1'b0;
		end else begin
			sram_discard_q <= cmd_fire && power_q == fcs_pkg::PWR_ACTIVE &&
				(cmd_op == fcs_pkg::OP_ULTRA_DOWN ||
				(cmd_op == fcs_pkg::OP_POWER_DOWN &&
				!sleep_depth_select_q));
		end
	end

	assign power_state = power_q;
	assign sram_retain = power_q != fcs_pkg::PWR_ULTRA;
	assign sram_discard = sram_discard_q;

	// ---------------------------------------------------------------
	// per-block locks
	// ---------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < fcs_pkg::NUM_BLOCKS; gi++) begin : g_lock
			always_ff @(posedge aclk) begin
				if (!aresetn || dev_reset) begin
					locks_q[gi] <= fcs_pkg::LOCKS_RST[gi];
				end else if (cmd_fire && protect_scheme_select_q &&
						power_q == fcs_pkg::PWR_ACTIVE &&
						cmd_block == fcs_pkg::BLOCK_IDX_W'(gi)) begin
					if (cmd_op == fcs_pkg::OP_BLOCK_LOCK)
						locks_q[gi] <= 1'b1;
					else if (cmd_op == fcs_pkg::OP_BLOCK_UNLOCK)
						locks_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	assign region_protect_en = ~protect_scheme_select_q;
	assign block_protect_en = protect_scheme_select_q;
	assign block_locked = locks_q;
	assign drive_level = drive_decode(drive_field_q);

	// ---------------------------------------------------------------
	// sequential programming
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn || dev_reset) begin
			program_mode_flag_q <= 1'b0;
			next_addr_q <= '0;
			prog_q <= '0;
		end else begin
			prog_q.strobe <= 1'b0;
			if (cmd_fire && power_q == fcs_pkg::PWR_ACTIVE) begin
				if (cmd_op == fcs_pkg::OP_SEQ_PROGRAM) begin
					program_mode_flag_q <= 1'b1;
					prog_q.strobe <= 1'b1;
					prog_q.data <= cmd_data;
					// first transfer takes the address, later ones continue
					prog_q.addr <= program_mode_flag_q ? next_addr_q :
						base_addr_q;
					next_addr_q <= (program_mode_flag_q ? next_addr_q :
						base_addr_q) + 1'b1;
				end else if (cmd_op == fcs_pkg::OP_SEQ_END) begin
					program_mode_flag_q <= 1'b0;
				end
			end
		end
	end

	assign program_mode_flag = program_mode_flag_q;
	assign prog_req = prog_q;

	// ---------------------------------------------------------------
	// axi4-lite read channel
	// ---------------------------------------------------------------
	assign s_axi_arready = ~rvalid_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= fcs_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q <= is_mapped(s_axi_araddr) ? fcs_pkg::RESP_OKAY :
				fcs_pkg::RESP_SLVERR;
			rdata_q <= 32'h0000_0000;
			case (s_axi_araddr)
				fcs_pkg::ADDR_PIN_DRIVE: begin
					rdata_q[fcs_pkg::HOLD_RESET_SEL_BIT] <= hold_reset_sel_q;
					rdata_q[fcs_pkg::DRIVE_HI_BIT:fcs_pkg::DRIVE_LO_BIT] <=
						drive_field_q;
					rdata_q[fcs_pkg::PROTECT_SCHEME_BIT] <= protect_scheme_select_q;
				end
				fcs_pkg::ADDR_POWER_PROG: begin
					rdata_q[fcs_pkg::SLEEP_DEPTH_BIT] <= sleep_depth_select_q;
					rdata_q[fcs_pkg::PROG_MODE_BIT] <= program_mode_flag_q;
				end
				fcs_pkg::ADDR_QUAD_CFG:
					rdata_q[fcs_pkg::FOUR_LINE_BIT] <= four_line_enable_q;
				fcs_pkg::ADDR_COMMAND:
					rdata_q[1:0] <= power_q;
				fcs_pkg::ADDR_PROG_ADDR:
					rdata_q[fcs_pkg::PROG_ADDR_W-1:0] <= program_mode_flag_q ?
						next_addr_q : base_addr_q;
				fcs_pkg::ADDR_BLOCK_LOCK:
					rdata_q[fcs_pkg::NUM_BLOCKS-1:0] <= locks_q;
				default: rdata_q <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

endmodule

/* fcs_regs_sva.sv */
// assertion checker for the flash config/status register bank
// assumes one aclk domain and a synchronous active-low reset
module fcs_regs_sva (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pin and write response
	input wire logic hold_reset_pin_n,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	// device side
	input wire logic hold_active,
	input wire logic pin_reset_active,
	input wire fcs_pkg::fcs_drive_s drive_level,
	input wire logic region_protect_en,
	input wire logic block_protect_en,
	input wire logic [fcs_pkg::NUM_BLOCKS-1:0] block_locked,
	input wire fcs_pkg::fcs_power_e power_state,
	input wire logic sram_retain,
	input wire logic sram_discard,
	input wire logic program_mode_flag,
	input wire fcs_pkg::fcs_prog_s prog_req
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_wr_done;
		$rose(s_axi_bvalid);
	endsequence
	sequence s_pin_rst;
		pin_reset_active || $past(pin_reset_active);
	endsequence

	a_role_excl: assert property (!(hold_active && pin_reset_active))
		else $error("hold and reset roles overlap");
	a_role_cause: assert property ((hold_active || pin_reset_active) |->
		!$past(hold_reset_pin_n, 2)) else $error("pin role without low pin");
	a_drive_decode: assert property ($onehot(drive_level))
		else $error("drive level not one-hot");
	a_scheme_excl: assert property (region_protect_en != block_protect_en)
		else $error("protect schemes not exclusive");
	a_retain_ultra: assert property (sram_retain ==
		(power_state != fcs_pkg::PWR_ULTRA)) else $error("retain mismatch");
	a_discard_pulse: assert property (sram_discard |->
		power_state == fcs_pkg::PWR_ULTRA ##1 !sram_discard)
		else $error("discard pulse wrong");
	a_wake_cause: assert property ((power_state == fcs_pkg::PWR_ACTIVE &&
		$past(power_state) != fcs_pkg::PWR_ACTIVE) |-> s_wr_done or s_pin_rst)
		else $error("left sleep without command");
	a_lock_cause: assert property ($changed(block_locked) |->
		s_wr_done or s_pin_rst) else $error("lock bits moved on their own");
	a_pin_reset: assert property (pin_reset_active |=>
		block_locked == '1 && !program_mode_flag)
		else $error("pin reset did not restore defaults");
	a_flag_cause: assert property ($rose(program_mode_flag) |-> s_wr_done)
		else $error("program flag rose without write");
	a_strobe_mode: assert property (prog_req.strobe |->
		program_mode_flag ##1 !prog_req.strobe) else $error("strobe wrong");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
endmodule

bind fcs_regs fcs_regs_sva fcs_regs_sva_i (
	.aclk(aclk), .aresetn(aresetn), .hold_reset_pin_n(hold_reset_pin_n),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .hold_active(hold_active),
	.pin_reset_active(pin_reset_active), .drive_level(drive_level),
	.region_protect_en(region_protect_en),
	.block_protect_en(block_protect_en), .block_locked(block_locked),
	.power_state(power_state), .sram_retain(sram_retain),
	.sram_discard(sram_discard), .program_mode_flag(program_mode_flag),
	.prog_req(prog_req)
);

/* fcs_axi_host.sv */
// axi4-lite master standing in for the command host
// assumes design outputs change only at rising edges
module fcs_axi_host (
	// clock
	input wire logic aclk,
	// write address and data
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	// write response
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	// read
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	// cycles before bready/rready rise, for a slow host
	int stall = 0;
	initial begin
		s_axi_awaddr <= 8'h00;
		s_axi_awvalid <= 1'b0;
		s_axi_wdata <= 32'h0;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b0;
		s_axi_araddr <= 8'h00;
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b0;
	end
	// handshakes judged at the falling edge, before the sampling edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw_go, w_go, b_go;
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (stall == 0);
		do begin
			@(negedge aclk);
			aw_go = s_axi_awvalid && s_axi_awready;
			w_go = s_axi_wvalid && s_axi_wready;
			b_go = s_axi_bvalid && s_axi_bready;
			r = s_axi_bresp;
			@(posedge aclk);
			n++;
			if (aw_go) s_axi_awvalid <= 1'b0;
			if (w_go) s_axi_wvalid <= 1'b0;
			if (n >= stall && !b_go) s_axi_bready <= 1'b1;
		end while (!b_go);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic a_go, r_go;
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (stall == 0);
		do begin
			@(negedge aclk);
			a_go = s_axi_arvalid && s_axi_arready;
			r_go = s_axi_rvalid && s_axi_rready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			n++;
			if (a_go) s_axi_arvalid <= 1'b0;
			if (n >= stall && !r_go) s_axi_rready <= 1'b1;
		end while (!r_go);
		s_axi_rready <= 1'b0;
	endtask
endmodule

/* fcs_regs_tb.sv */
// self-checking bench for the flash config/status register bank
// assumes the host model and the bound checker
module fcs_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, hold_reset_pin_n;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, hold_active, pin_reset_active;
	logic region_protect_en, block_protect_en, sram_retain, sram_discard;
	logic program_mode_flag;
	logic [fcs_pkg::NUM_BLOCKS-1:0] block_locked, m_locks;
	fcs_pkg::fcs_drive_s drive_level;
	fcs_pkg::fcs_power_e power_state, m_pwr;
	fcs_pkg::fcs_prog_s prog_req;
	int n_errors = 0;
	int total_checks = 0;
	int n_disc = 0;
	int m_disc = 0;
	logic [15:0] rnd = 16'he196;
	logic [7:0] m_cfg;
	logic m_depth, m_quad, m_flag;
	logic [23:0] m_base, m_next;
	logic [31:0] exp_q[$], got_q[$];
	logic [3:0] drv_tab [4] = '{4'h1, 4'h8, 4'h4, 4'h2};

	fcs_regs fcs_regs_i (.*);
	fcs_axi_host fcs_axi_host_i (.aclk(aclk), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_all();
		logic h, r;
		h = !hold_reset_pin_n && !m_quad && !m_cfg[7];
		r = !hold_reset_pin_n && !m_quad && m_cfg[7];
		if (r) begin
			m_locks = '1;
			m_pwr = fcs_pkg::PWR_ACTIVE;
			m_flag = 1'b0;
		end
		check(32'({hold_active, pin_reset_active}), 32'({h, r}));
		check(32'(drive_level), 32'(drv_tab[m_cfg[6:5]]));
		check(32'({region_protect_en, block_protect_en}),
			32'({!m_cfg[2], m_cfg[2]}));
		check(32'(block_locked), 32'(m_locks));
		check(32'(power_state), 32'(m_pwr));
		check(32'(sram_retain), 32'(m_pwr != fcs_pkg::PWR_ULTRA));
		check(32'(program_mode_flag), 32'(m_flag));
		check(32'(got_q.size()), 32'(exp_q.size()));
		while (exp_q.size() > 0 && got_q.size() > 0)
			check(got_q.pop_front(), exp_q.pop_front());
	endtask
	task automatic mwr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		logic ok;
		ok = 1'b1;
		case (a)
		fcs_pkg::ADDR_PIN_DRIVE: m_cfg = d[7:0] & 8'he4;
		fcs_pkg::ADDR_POWER_PROG: m_depth = d[7];
		fcs_pkg::ADDR_QUAD_CFG: m_quad = d[1];
		fcs_pkg::ADDR_PROG_ADDR: m_base = d[23:0];
		fcs_pkg::ADDR_BLOCK_LOCK: ;
		fcs_pkg::ADDR_COMMAND: begin
			if (m_pwr != fcs_pkg::PWR_ACTIVE) begin
				if (d[7:0] == fcs_pkg::OP_WAKE) m_pwr = fcs_pkg::PWR_ACTIVE;
			end else begin
				case (d[7:0])
				fcs_pkg::OP_BLOCK_LOCK: if (m_cfg[2]) m_locks[d[11:8]] = 1'b1;
				fcs_pkg::OP_BLOCK_UNLOCK: if (m_cfg[2]) m_locks[d[11:8]] = 1'b0;
				fcs_pkg::OP_ULTRA_DOWN: m_pwr = fcs_pkg::PWR_ULTRA;
				fcs_pkg::OP_POWER_DOWN: m_pwr = m_depth ? fcs_pkg::PWR_DEEP
					: fcs_pkg::PWR_ULTRA;
				fcs_pkg::OP_SEQ_END: m_flag = 1'b0;
				fcs_pkg::OP_SEQ_PROGRAM: begin
					if (!m_flag) m_next = m_base;
					exp_q.push_back({m_next, d[31:24]});
					m_next++;
					m_flag = 1'b1;
				end
				default: ;
				endcase
				if (m_pwr == fcs_pkg::PWR_ULTRA) m_disc++;
			end
		end
		default: ok = 1'b0;
		endcase
		fcs_axi_host_i.wr(a, d, r);
		check(32'(r), ok ? 32'(fcs_pkg::RESP_OKAY) : 32'(fcs_pkg::RESP_SLVERR));
		@(negedge aclk);
		check_all();
	endtask
	task automatic mrd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		fcs_axi_host_i.rd(a, d, r);
		check(d, e);
		check(32'(r), 32'(er));
	endtask
	// two sync flops: four cycles settle the pin
	task automatic set_pin(input logic v);
		@(posedge aclk);
		hold_reset_pin_n <= v;
		repeat (4) @(posedge aclk);
		@(negedge aclk);
		check_all();
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(negedge aclk) begin
		if (prog_req.strobe === 1'b1) got_q.push_back({prog_req.addr, prog_req.data});
		if (sram_discard === 1'b1) n_disc++;
	end
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		end_of_test();
	end

	initial begin
		aresetn = 1'b0;
		hold_reset_pin_n = 1'b1;
		m_cfg = 8'h20;
		{m_depth, m_quad, m_flag, m_base, m_next} = '0;
		m_locks = '1;
		m_pwr = fcs_pkg::PWR_ACTIVE;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		check_all();
		mrd(fcs_pkg::ADDR_PIN_DRIVE, 32'h20, fcs_pkg::RESP_OKAY);
		mrd(fcs_pkg::ADDR_POWER_PROG, 32'h0, fcs_pkg::RESP_OKAY);
		for (int c = 0; c < 4; c++) begin
			rnd = lfsr(rnd);
			mwr(fcs_pkg::ADDR_PIN_DRIVE, {rnd, rnd[8:0], 2'(c), rnd[4:0]});
			mrd(fcs_pkg::ADDR_PIN_DRIVE, {24'h0, m_cfg}, fcs_pkg::RESP_OKAY);
		end
		// scheme 0 from step 6 on
		mwr(fcs_pkg::ADDR_PIN_DRIVE, 32'h24);
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			if (i == 6) mwr(fcs_pkg::ADDR_PIN_DRIVE, 32'h20);
			mwr(fcs_pkg::ADDR_COMMAND, {20'h0, rnd[3:0], i[0] ?
				fcs_pkg::OP_BLOCK_LOCK : fcs_pkg::OP_BLOCK_UNLOCK});
		end
		mwr(fcs_pkg::ADDR_BLOCK_LOCK, 32'h0);
		mrd(fcs_pkg::ADDR_BLOCK_LOCK, 32'(m_locks), fcs_pkg::RESP_OKAY);
		mwr(fcs_pkg::ADDR_PIN_DRIVE, 32'h24);
		fcs_axi_host_i.stall = 3;
		for (int k = 0; k < 3; k++) begin
			mwr(fcs_pkg::ADDR_POWER_PROG, {24'h0, k[0], 7'h7f});
			mwr(fcs_pkg::ADDR_COMMAND, {24'h0, k == 2 ?
				fcs_pkg::OP_ULTRA_DOWN : fcs_pkg::OP_POWER_DOWN});
			mwr(fcs_pkg::ADDR_COMMAND, {20'h0, 4'h5, fcs_pkg::OP_BLOCK_UNLOCK});
			mrd(fcs_pkg::ADDR_POWER_PROG, {24'h0, k[0], 7'h0}, fcs_pkg::RESP_OKAY);
			mwr(fcs_pkg::ADDR_COMMAND, {24'h0, fcs_pkg::OP_WAKE});
		end
		fcs_axi_host_i.stall = 0;
		rnd = lfsr(rnd);
		mwr(fcs_pkg::ADDR_PROG_ADDR, {8'h0, rnd, rnd[7:0]});
		for (int j = 0; j < 5; j++) begin
			rnd = lfsr(rnd);
			if (j == 3) mwr(fcs_pkg::ADDR_COMMAND, {24'h0, fcs_pkg::OP_SEQ_END});
			mwr(fcs_pkg::ADDR_COMMAND, {rnd[7:0], 16'h0, fcs_pkg::OP_SEQ_PROGRAM});
			if (j == 1) mrd(fcs_pkg::ADDR_PROG_ADDR, {8'h0, m_next},
				fcs_pkg::RESP_OKAY);
			if (j == 1) mrd(fcs_pkg::ADDR_POWER_PROG, 32'h40,
				fcs_pkg::RESP_OKAY);
		end
		set_pin(1'b0);
		mwr(fcs_pkg::ADDR_PIN_DRIVE, 32'ha4);
		mwr(fcs_pkg::ADDR_QUAD_CFG, 32'h2);
		set_pin(1'b1);
		mwr(fcs_pkg::ADDR_QUAD_CFG, 32'h0);
		mwr(8'h18, 32'h0);
		mrd(8'h18, 32'h0, fcs_pkg::RESP_SLVERR);
		check(32'(n_disc), 32'(m_disc));
		end_of_test();
	end
endmodule
